// File: core/csb_pkg.sv
// package: register map and timing constants
`default_nettype none
package csb_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [11:0] CSB_OFS_STOP_CTRL  = 12'h0d1; // oscillator_stop_control
  localparam logic [11:0] CSB_OFS_STATUS     = 12'h0d4; // clock status, read only
  localparam logic [11:0] CSB_OFS_OPTIONS    = 12'h0d8; // option bits, read only
  localparam logic [11:0] CSB_OFS_INSTR      = 12'h0dc; // instruction length select
  localparam int          CSB_STOP_BIT       = 2;
  localparam logic [7:0]  CSB_STOP_CTRL_RST  = 8'h00;
  localparam logic [1:0]  CSB_INSTR_RST      = 2'h0;
  // ****************************************************************
  // clock division and timing
  // ****************************************************************
  localparam int          CSB_PERIPH_DIV     = 12;
  localparam int          CSB_CORE_DIV       = 13;
  localparam int          CSB_CLK_MHZ        = 25;
  localparam int          CSB_STARTUP_US     = 1000;  // main oscillator start-up
  localparam int          CSB_STARTUP_CYC    = CSB_STARTUP_US * CSB_CLK_MHZ;
  localparam int          CSB_MIN_PERIOD_CYC = 2;     // safeguard limit, sys cycles
  localparam int          CSB_BACKUP_DIV     = 64;    // backup osc period, sys cycles
  // machine cycles per instruction
  localparam logic [2:0]  CSB_INSTR_2        = 3'h2;
  localparam logic [2:0]  CSB_INSTR_4        = 3'h4;
  localparam logic [2:0]  CSB_INSTR_5        = 3'h5;
  // ****************************************************************
  // axi responses
  // ****************************************************************
  localparam logic [1:0]  CSB_RESP_OKAY      = 2'h0;
  localparam logic [1:0]  CSB_RESP_SLVERR    = 2'h2;
  typedef enum logic [1:0] {
    CSB_SRC_MAIN   = 2'b00,
    CSB_SRC_BACKUP = 2'b01,
    CSB_SRC_SWITCH = 2'b10
  } csb_src_type;
endpackage
`default_nettype wire

// File: core/csb_divider.sv
// module: modulo-n enable divider
`default_nettype none
module csb_divider #(
  parameter int DIV = 12
) (
  input  wire logic clk_sys,     // system clock
  input  wire logic srst,        // sync reset
  input  wire logic tick,        // one internal clock cycle
  output logic      pulse        // one cycle per DIV ticks
);
  localparam int W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);
  logic [W-1:0] cnt_q;
  logic         pulse_q;
  wire          wrap = tick && (cnt_q == LAST);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_q   <= '0;
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= wrap;
      if (wrap)
        cnt_q <= '0;
      else if (tick)
        cnt_q <= cnt_q + W'(1);
    end
  end
  assign pulse = pulse_q;
endmodule
`default_nettype wire

// File: core/csb_clock_safeguard.sv
// module: internal clock, safeguard, backup oscillator, dividers
// ****************************************************************
// ****************************************************************
`default_nettype none
module csb_clock_safeguard
  import csb_pkg::*;
#(
  parameter int STARTUP_CYC = csb_pkg::CSB_STARTUP_CYC,
  parameter int BACKUP_DIV  = csb_pkg::CSB_BACKUP_DIV,
  parameter int MIN_PERIOD  = csb_pkg::CSB_MIN_PERIOD_CYC,
  parameter int MISS_LIMIT  = 8
) (
  input  wire logic        clk_sys,               // system clock
  input  wire logic        srst,                  // sync reset
  input  wire logic        mainOscIn,             // main osc pin
  input  wire logic        safeguardEnableOption, // option bit
  input  wire logic        oscTypeOption,         // option bit
  input  wire logic [11:0] s_axi_awaddr,          // write address
  input  wire logic        s_axi_awvalid,         // aw valid
  output logic             s_axi_awready,         // aw ready
  input  wire logic [31:0] s_axi_wdata,           // write data
  input  wire logic [3:0]  s_axi_wstrb,           // write strobes
  input  wire logic        s_axi_wvalid,          // w valid
  output logic             s_axi_wready,          // w ready
  output logic [1:0]       s_axi_bresp,           // write response
  output logic             s_axi_bvalid,          // b valid
  input  wire logic        s_axi_bready,          // b ready
  input  wire logic [11:0] s_axi_araddr,          // read address
  input  wire logic        s_axi_arvalid,         // ar valid
  output logic             s_axi_arready,         // ar ready
  output logic [31:0]      s_axi_rdata,           // read data
  output logic [1:0]       s_axi_rresp,           // read response
  output logic             s_axi_rvalid,          // r valid
  input  wire logic        s_axi_rready,          // r ready
  output logic             internalTick,          // internal tick
  output logic             periphEnable,          // tick / 12
  output logic             machineCycle,          // tick / 13
  output logic             instrDone,             // instruction end
  output logic             onBackupOsc,           // on backup osc
  output logic             resistorNetworkMode,   // rc mode
  output logic             porDone                // power-on delay over
);
  // ****************************************************************
  // pin synchroniser
  // ****************************************************************
  logic [2:0] pinSync_q;
  logic       mainLevel_q;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pinSync_q   <= 3'h0;
      mainLevel_q <= 1'b0;
    end else begin
      pinSync_q <= {pinSync_q[1:0], mainOscIn};
      if (pinSync_q[1] == pinSync_q[2])
        mainLevel_q <= pinSync_q[2];
    end
  end
  logic mainLevelPrev_q;
  always_ff @(posedge clk_sys) begin
    if (srst)
      mainLevelPrev_q <= 1'b0;
    else
      mainLevelPrev_q <= mainLevel_q;
  end
  wire mainRise = mainLevel_q && !mainLevelPrev_q;

  // ****************************************************************
  // options caught once after reset release
  // ****************************************************************
  logic optValid_q;
  logic sgEnable_q;
  logic rcMode_q;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      optValid_q <= 1'b0;
      sgEnable_q <= 1'b0;
      rcMode_q   <= 1'b0;
    end else if (!optValid_q) begin
      // latched only here: software cannot change it
      optValid_q <= 1'b1;
      sgEnable_q <= safeguardEnableOption;
      rcMode_q   <= oscTypeOption;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] stopCtrl_q;
  logic [1:0] instrSel_q;
  wire        stopReq = stopCtrl_q[CSB_STOP_BIT] && sgEnable_q;

  // ****************************************************************
  // main oscillator run state and restart delay
  // ****************************************************************
  localparam int SUW = $clog2(STARTUP_CYC + 1);
  localparam logic [SUW-1:0] SU_LAST = SUW'(STARTUP_CYC);
  logic [SUW-1:0] startCnt_q;
  logic           mainRunning_q;
  logic           restartWait_q;   // start-up over, finishing current instruction
  wire            startupDone = (startCnt_q == SU_LAST);

  // no main rise within MISS_LIMIT cycles
  localparam int MW = $clog2(MISS_LIMIT + 1);
  localparam logic [MW-1:0] MISS_LAST = MW'(MISS_LIMIT);
  logic [MW-1:0] missCnt_q;
  wire           mainMissing = (missCnt_q == MISS_LAST);

  always_ff @(posedge clk_sys) begin
    if (srst)
      missCnt_q <= '0;
    else if (mainRise || stopReq)
      missCnt_q <= mainRise ? '0 : MISS_LAST;
    else if (!mainMissing)
      missCnt_q <= missCnt_q + MW'(1);
  end

  // ****************************************************************
  // source selection
  // ****************************************************************
  csb_src_type src_q;
  csb_src_type src_d;
  logic        backupTick;
  logic        mainTick;
  logic        backupRun_q;

  // main stopped, missing or starting
  wire wantBackup = sgEnable_q && (stopReq || mainMissing || !mainRunning_q);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      startCnt_q    <= '0;
      mainRunning_q <= 1'b0;
      restartWait_q <= 1'b0;
    end else if (stopReq) begin
      startCnt_q    <= '0;
      mainRunning_q <= 1'b0;
      restartWait_q <= 1'b0;
    end else if (!mainRunning_q) begin
      if (!startupDone) begin
        if (mainRise || (sgEnable_q && backupTick))
          startCnt_q <= startCnt_q + SUW'(1);
      end else if (!restartWait_q) begin
        restartWait_q <= 1'b1;
      end else if (instrDone_q || !porDone_q) begin
        mainRunning_q <= 1'b1;
        restartWait_q <= 1'b0;
      end
    end
  end

  always_comb begin
    src_d = src_q;
    case (src_q)
      CSB_SRC_MAIN:
        if (wantBackup)
          src_d = CSB_SRC_SWITCH;
      CSB_SRC_SWITCH:
        // switch on a backup tick: no short phase
        if (backupTick)
          src_d = wantBackup ? CSB_SRC_BACKUP : CSB_SRC_MAIN;
      CSB_SRC_BACKUP:
        if (!wantBackup && mainRise)
          src_d = CSB_SRC_MAIN;
      default:
        src_d = CSB_SRC_MAIN;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      src_q       <= CSB_SRC_MAIN;
      backupRun_q <= 1'b0;
    end else begin
      src_q       <= src_d;
      backupRun_q <= wantBackup || (src_q != CSB_SRC_MAIN);
    end
  end

  // backup osc runs only while enabled
  localparam int BW = $clog2(BACKUP_DIV);
  localparam logic [BW-1:0] B_LAST = BW'(BACKUP_DIV - 1);
  logic [BW-1:0] backupCnt_q;
  always_ff @(posedge clk_sys) begin
    if (srst || !backupRun_q)
      backupCnt_q <= '0;
    else if (backupCnt_q == B_LAST)
      backupCnt_q <= '0;
    else
      backupCnt_q <= backupCnt_q + BW'(1);
  end
  assign backupTick = backupRun_q && (backupCnt_q == B_LAST);

  // ****************************************************************
  // safeguard: minimum spacing between internal ticks
  // ****************************************************************
  localparam int GW = $clog2(MIN_PERIOD + 1);
  localparam logic [GW-1:0] G_LAST = GW'(MIN_PERIOD);
  logic [GW-1:0] gapCnt_q;
  wire           gapOk = (gapCnt_q >= G_LAST);
  // closer edges are spikes or over-frequency
  assign mainTick = mainRise && (!sgEnable_q || gapOk);

  wire tick = (src_q == CSB_SRC_MAIN) ? mainTick
            : (src_q == CSB_SRC_BACKUP) ? backupTick : 1'b0;

  always_ff @(posedge clk_sys) begin
    if (srst)
      gapCnt_q <= '0;
    else if (tick)
      gapCnt_q <= '0;
    else if (!gapOk)
      gapCnt_q <= gapCnt_q + GW'(1);
  end

  // ****************************************************************
  // dividers and instruction timing
  // ****************************************************************
  logic tickOut_q;
  always_ff @(posedge clk_sys) begin
    if (srst)
      tickOut_q <= 1'b0;
    else
      tickOut_q <= tick;
  end

  logic periphPulse;
  logic corePulse;
  csb_divider #(.DIV(CSB_PERIPH_DIV)) uPeriph (
    .clk_sys (clk_sys),
    .srst    (srst),
    .tick    (tick),
    .pulse   (periphPulse)
  );
  csb_divider #(.DIV(CSB_CORE_DIV)) uCore (
    .clk_sys (clk_sys),
    .srst    (srst),
    .tick    (tick),
    .pulse   (corePulse)
  );

  wire [2:0] instrLen = (instrSel_q == 2'h1) ? CSB_INSTR_4
                      : (instrSel_q == 2'h2) ? CSB_INSTR_5 : CSB_INSTR_2;
  logic [2:0] mcCnt_q;
  logic       instrDone_q;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mcCnt_q     <= 3'h0;
      instrDone_q <= 1'b0;
    end else begin
      instrDone_q <= 1'b0;
      if (corePulse) begin
        if (mcCnt_q + 3'h1 >= instrLen) begin
          mcCnt_q     <= 3'h0;
          instrDone_q <= 1'b1;
        end else begin
          mcCnt_q <= mcCnt_q + 3'h1;
        end
      end
    end
  end

  logic porDone_q;
  always_ff @(posedge clk_sys) begin
    if (srst)
      porDone_q <= 1'b0;
    else if (mainRunning_q || (!sgEnable_q && startupDone && optValid_q))
      porDone_q <= 1'b1;
  end

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  logic        awHeld_q, wHeld_q, bValid_q, rValid_q;
  logic [11:0] awAddr_q;
  logic [7:0]  wByte_q;
  logic        wLane0_q;
  logic [1:0]  bResp_q, rResp_q;
  logic [31:0] rData_q;

  wire awTake = s_axi_awvalid && !awHeld_q && !bValid_q;
  wire wTake  = s_axi_wvalid && !wHeld_q && !bValid_q;
  wire doWrite = awHeld_q && wHeld_q && !bValid_q;
  // one register per word: byte address is four times the index
  function automatic logic isReg(input logic [11:0] addr, input logic [11:0] idx);
    return addr == {idx[9:0], 2'b00};
  endfunction
  wire wrCtrl  = isReg(awAddr_q, CSB_OFS_STOP_CTRL);
  wire wrInstr = isReg(awAddr_q, CSB_OFS_INSTR);
  wire wrHit   = wrCtrl || wrInstr || isReg(awAddr_q, CSB_OFS_STATUS)
              || isReg(awAddr_q, CSB_OFS_OPTIONS);
  wire arTake  = s_axi_arvalid && !rValid_q;

  wire [31:0] status = {27'h0, porDone_q, mainRunning_q, backupRun_q, src_q};
  wire [31:0] options = {29'h0, optValid_q, rcMode_q, sgEnable_q};
  wire rdCtrl = isReg(s_axi_araddr, CSB_OFS_STOP_CTRL);
  wire rdStat = isReg(s_axi_araddr, CSB_OFS_STATUS);
  wire rdOpt  = isReg(s_axi_araddr, CSB_OFS_OPTIONS);
  wire rdIns  = isReg(s_axi_araddr, CSB_OFS_INSTR);
  wire rdHit  = rdCtrl || rdStat || rdOpt || rdIns;
  wire [31:0] rdMux = rdCtrl ? {24'h0, stopCtrl_q} : rdStat ? status
                    : rdOpt ? options : rdIns ? {30'h0, instrSel_q} : 32'h0;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      bValid_q <= 1'b0;
      awAddr_q <= 12'h0;
      wByte_q  <= 8'h0;
      wLane0_q <= 1'b0;
      bResp_q  <= CSB_RESP_OKAY;
    end else begin
      if (awTake) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (wTake) begin
        wHeld_q  <= 1'b1;
        wByte_q  <= s_axi_wdata[7:0];
        wLane0_q <= s_axi_wstrb[0];
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q  <= 1'b0;
        bValid_q <= 1'b1;
        bResp_q  <= wrHit ? CSB_RESP_OKAY : CSB_RESP_SLVERR;
      end else if (bValid_q && s_axi_bready) begin
        bValid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stopCtrl_q <= CSB_STOP_CTRL_RST;
      instrSel_q <= CSB_INSTR_RST;
    end else if (doWrite && wLane0_q) begin
      if (wrCtrl)
        stopCtrl_q <= wByte_q;
      if (wrInstr)
        instrSel_q <= wByte_q[1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rValid_q <= 1'b0;
      rData_q  <= 32'h0;
      rResp_q  <= CSB_RESP_OKAY;
    end else if (arTake) begin
      rValid_q <= 1'b1;
      rData_q  <= rdMux;
      rResp_q  <= rdHit ? CSB_RESP_OKAY : CSB_RESP_SLVERR;
    end else if (rValid_q && s_axi_rready) begin
      rValid_q <= 1'b0;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  logic onBackup_q;
  logic rcOut_q;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      onBackup_q <= 1'b0;
      rcOut_q    <= 1'b0;
    end else begin
      onBackup_q <= (src_q == CSB_SRC_BACKUP);
      rcOut_q    <= rcMode_q;
    end
  end

  assign s_axi_awready       = awHeld_q;
  assign s_axi_wready        = wHeld_q;
  assign s_axi_bvalid        = bValid_q;
  assign s_axi_bresp         = bResp_q;
  assign s_axi_arready       = rValid_q;
  assign s_axi_rvalid        = rValid_q;
  assign s_axi_rdata         = rData_q;
  assign s_axi_rresp         = rResp_q;
  assign internalTick        = tickOut_q;
  assign periphEnable        = periphPulse;
  assign machineCycle        = corePulse;
  assign instrDone           = instrDone_q;
  assign onBackupOsc         = onBackup_q;
  assign resistorNetworkMode = rcOut_q;
  assign porDone             = porDone_q;
endmodule
`default_nettype wire

// File: sim/csb_clock_safeguard_props.sv
// checker: port-level assertions
`default_nettype none
module csb_clock_safeguard_props
  import csb_pkg::*;
#(
  parameter int MISS_LIMIT = 8,
  parameter int BACKUP_DIV = 64
) (
  input wire logic        clk_sys,               // system clock
  input wire logic        srst,                  // sync reset
  input wire logic        mainOscIn,             // main osc pin
  input wire logic        safeguardEnableOption, // option bit
  input wire logic        oscTypeOption,         // option bit
  input wire logic        s_axi_bvalid,          // write resp valid
  input wire logic        s_axi_bready,          // write resp ready
  input wire logic        s_axi_rvalid,          // read valid
  input wire logic        s_axi_rready,          // read ready
  input wire logic [31:0] s_axi_rdata,           // read data
  input wire logic        internalTick,          // internal tick
  input wire logic        periphEnable,          // tick / 12
  input wire logic        machineCycle,          // tick / 13
  input wire logic        instrDone,             // instruction end
  input wire logic        onBackupOsc,           // on backup osc
  input wire logic        resistorNetworkMode,   // rc mode
  input wire logic        porDone                // power-on delay over
);
  timeunit 1ns;
  timeprecision 100ps;
  // miss limit, sync delay plus two backup periods
  localparam int MISS_WAIT = MISS_LIMIT + 2 * BACKUP_DIV + 8;
  int   relCnt, tickP, tickC, mcCnt, quietCnt;
  logic sgLatch, rcLatch, pSeen, cSeen, iSeen;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // ****************************************************************
  // helper counters
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    tickP    <= periphEnable ? 0 : tickP + internalTick;
    tickC    <= machineCycle ? 0 : tickC + internalTick;
    mcCnt    <= instrDone ? 0 : mcCnt + machineCycle;
    quietCnt <= ($changed(mainOscIn) || srst) ? 0 : quietCnt + 1;
    // options caught at first edge after release
    if (relCnt == 0) begin
      sgLatch <= safeguardEnableOption;
      rcLatch <= oscTypeOption;
    end
    if (srst) begin
      relCnt <= 0;
      pSeen  <= 1'b0;
      cSeen  <= 1'b0;
      iSeen  <= 1'b0;
    end else begin
      relCnt <= (relCnt < 3) ? relCnt + 1 : 3;
      pSeen  <= pSeen | periphEnable;
      cSeen  <= cSeen | machineCycle;
      iSeen  <= iSeen | instrDone;
    end
  end
  AST_PERIPH_DIV: assert property (
    periphEnable && pSeen |-> tickP + internalTick == CSB_PERIPH_DIV)
    else $error("periph divide");
  AST_CORE_DIV: assert property (
    machineCycle && cSeen |-> tickC + internalTick == CSB_CORE_DIV)
    else $error("core divide");
  AST_INSTR_LEN: assert property (
    instrDone && iSeen |-> (mcCnt + machineCycle) inside {2, 4, 5})
    else $error("instr length");
  AST_TICK_SPACING: assert property (
    sgLatch && internalTick |=> !internalTick)
    else $error("tick spacing");
  AST_RC_MODE: assert property (
    relCnt == 3 |-> resistorNetworkMode == rcLatch)
    else $error("rc mode");
  AST_SG_OFF_NO_BACKUP: assert property (
    relCnt == 3 && !sgLatch |-> !onBackupOsc)
    else $error("backup with guard off");
  AST_MISS_BACKUP: assert property (
    sgLatch && quietCnt == MISS_WAIT |-> onBackupOsc)
    else $error("no backup on miss");
  AST_RESET_QUIET: assert property (
    relCnt == 0 |-> !porDone && !onBackupOsc && !s_axi_bvalid && !s_axi_rvalid)
    else $error("active at reset");
  AST_BVALID_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  AST_RVALID_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rvalid unstable");
  cover property (onBackupOsc ##1 !onBackupOsc);
  cover property (instrDone && iSeen && mcCnt + machineCycle == 5);
  cover property (sgLatch && quietCnt == MISS_WAIT);
endmodule
bind csb_clock_safeguard csb_clock_safeguard_props #(
  .MISS_LIMIT(MISS_LIMIT),
  .BACKUP_DIV(BACKUP_DIV)
) i_props (
  .clk_sys, .srst, .mainOscIn, .safeguardEnableOption, .oscTypeOption,
  .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .internalTick, .periphEnable, .machineCycle, .instrDone, .onBackupOsc,
  .resistorNetworkMode, .porDone
);
`default_nettype wire

// File: sim/csb_osc_model.sv
// model: main oscillator pin, a crystal that can die or ring with spikes
`default_nettype none
module csb_osc_model (
  input  wire logic run,    // oscillate when high
  input  wire logic fast,   // spike burst far above the safeguard limit
  output logic      oscOut  // oscillator pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // dead crystal freezes the pin; period unrelated to clk_sys
  initial begin
    oscOut = 1'b0;
    forever begin
      #(fast ? 13 : 170);
      if (run) oscOut = ~oscOut;
    end
  end
endmodule
`default_nettype wire

// File: sim/csb_clock_safeguard_tb.sv
// testbench: clock safeguard scenarios
`default_nettype none
module csb_clock_safeguard_tb;
  import csb_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LIMIT = 20000;
  localparam int MISS  = 8;
  localparam int BDIV  = 8;
  logic        clk_sys, srst, mainOscIn, oscRun, oscFast;
  logic        safeguardEnableOption, oscTypeOption;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        internalTick, periphEnable, machineCycle, instrDone;
  logic        onBackupOsc, resistorNetworkMode, porDone;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          cycles = 0;
  csb_clock_safeguard #(.STARTUP_CYC(20), .BACKUP_DIV(BDIV), .MIN_PERIOD(2), .MISS_LIMIT(MISS))
  i_dut (
    .clk_sys, .srst, .mainOscIn, .safeguardEnableOption, .oscTypeOption,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .internalTick, .periphEnable, .machineCycle,
    .instrDone, .onBackupOsc, .resistorNetworkMode, .porDone
  );
  csb_osc_model i_osc (.run(oscRun), .fast(oscFast), .oscOut(mainOscIn));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // one register per word
  function automatic logic [11:0] ba(input logic [11:0] idx);
    return {idx[9:0], 2'b00};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // ****************************************************************
  // bus master
  // ****************************************************************
  task automatic axiWrite(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw = 1'b0;
    logic w = 1'b0;
    s_axi_awaddr  <= ba(a);
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk_sys);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    // late ready: the response must stand
    while (s_axi_bvalid !== 1'b1) @(posedge clk_sys);
    s_axi_bready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic readCheck(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er,
                           input string what);
    s_axi_araddr  <= ba(a);
    s_axi_arvalid <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready  <= 1'b1;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    check(s_axi_rdata, exp, what);
    check(s_axi_rresp, er, "read resp");
    s_axi_rready <= 1'b0;
  endtask
  task automatic waitFor(input bit por, input logic want, input int lim);
    int k = 0;
    while ((por ? porDone : onBackupOsc) !== want && k < lim) begin
      @(posedge clk_sys);
      k++;
    end
    check(por ? porDone : onBackupOsc, want, por ? "porDone" : "onBackupOsc");
  endtask
  task automatic doReset(input logic sg, input logic rc);
    safeguardEnableOption <= sg;
    oscTypeOption         <= rc;
    srst                  <= 1'b1;
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs;
    logic [1:0] r;
    waitFor(1'b1, 1'b1, 1000);
    waitFor(1'b0, 1'b0, 20);
    readCheck(CSB_OFS_STOP_CTRL, 32'(CSB_STOP_CTRL_RST), CSB_RESP_OKAY, "stop ctrl");
    readCheck(CSB_OFS_OPTIONS, 32'h5, CSB_RESP_OKAY, "options");
    axiWrite(CSB_OFS_STOP_CTRL, 8'hfb, r);
    repeat (40) @(posedge clk_sys);
    check(onBackupOsc, 1'b0, "unused bits");
    readCheck(CSB_OFS_STOP_CTRL, 32'hfb, CSB_RESP_OKAY, "stop ctrl fb");
    axiWrite(12'h004, 8'h04, r);
    check(r, CSB_RESP_SLVERR, "unmapped write resp");
    readCheck(12'h004, 32'h0, CSB_RESP_SLVERR, "unmapped read");
    axiWrite(CSB_OFS_STOP_CTRL, 8'h00, r);
  endtask
  task automatic t_instr_len;
    logic [1:0] r;
    logic [2:0] len [3] = '{CSB_INSTR_2, CSB_INSTR_4, CSB_INSTR_5};
    int         n;
    for (int s = 0; s < 3; s++) begin
      axiWrite(CSB_OFS_INSTR, 8'(s), r);
      // finish instr in flight and one more
      repeat (2) do @(posedge clk_sys); while (instrDone !== 1'b1);
      n = 0;
      do begin
        @(posedge clk_sys);
        n += machineCycle;
      end while (instrDone !== 1'b1);
      check(32'(n), 32'(len[s]), "mc per instr");
    end
  endtask
  task automatic t_sw_stop;
    logic [1:0] r;
    int         k = 0;
    axiWrite(CSB_OFS_STOP_CTRL, 8'h04, r);
    waitFor(1'b0, 1'b1, 40);
    readCheck(CSB_OFS_STATUS, 32'h15, CSB_RESP_OKAY, "status on backup");
    repeat (300) begin
      @(posedge clk_sys);
      k += machineCycle;
    end
    check(32'(k > 0), 32'h1, "mc on backup");
    axiWrite(CSB_OFS_STOP_CTRL, 8'h00, r);
    repeat (40) @(posedge clk_sys);
    check(onBackupOsc, 1'b1, "backup in start-up");
    waitFor(1'b0, 1'b0, 900);
  endtask
  task automatic t_missing_edge;
    int k = 0;
    oscRun <= 1'b0;
    waitFor(1'b0, 1'b1, MISS + 2 * BDIV + 8);
    oscRun <= 1'b1;
    waitFor(1'b0, 1'b0, 900);
    oscFast <= 1'b1;
    repeat (200) begin
      @(posedge clk_sys);
      k += internalTick;
    end
    oscFast <= 1'b0;
    check(32'(k <= 100), 32'h1, "ticks under spikes");
  endtask
  task automatic t_sg_off;
    logic [1:0] r;
    int         k = 0;
    doReset(1'b0, 1'b1);
    repeat (4) @(posedge clk_sys);
    check(resistorNetworkMode, 1'b1, "rc mode");
    readCheck(CSB_OFS_OPTIONS, 32'h6, CSB_RESP_OKAY, "options sg off");
    safeguardEnableOption <= 1'b1;
    axiWrite(CSB_OFS_STOP_CTRL, 8'h04, r);
    repeat (100) begin
      @(posedge clk_sys);
      k += internalTick;
    end
    check(onBackupOsc, 1'b0, "stop ignored");
    check(32'(k > 0), 32'h1, "main ticks");
    readCheck(CSB_OFS_OPTIONS, 32'h6, CSB_RESP_OKAY, "options kept");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    {srst, oscRun, oscFast, safeguardEnableOption, oscTypeOption} = 5'b11010;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'h1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    @(posedge clk_sys);
    doReset(1'b1, 1'b0);
    t_regs();
    t_instr_len();
    t_sw_stop();
    t_missing_edge();
    t_sg_off();
    report_and_stop();
  end
endmodule
`default_nettype wire
